// file: swl_consts.vh
`ifndef SWL_CONSTS_VH
`define SWL_CONSTS_VH
// Times in ns; cycle counts derived at 25 ns per clock.
`define SWL_CLK_NS          25
`define SWL_RSTL_STD_NS     480000
`define SWL_RSTL_OD_NS      70000
`define SWL_RSTH_STD_NS     480000
`define SWL_RSTH_OD_NS      48000
`define SWL_MSP_STD_NS      70000
`define SWL_MSP_OD_NS       8500
`define SWL_SLOT_STD_NS     86000
`define SWL_SLOT_OD_NS      16000
`define SWL_W0L_STD_NS      60000
`define SWL_W0L_OD_NS       8000
`define SWL_W1L_STD_NS      5000
`define SWL_W1L_OD_NS       1000
`define SWL_RL_STD_NS       5000
`define SWL_RL_OD_NS        1000
`define SWL_MSR_STD_NS      13000
`define SWL_MSR_OD_NS       2000
`define SWL_FALL_NS         0
`define SWL_CYC(ns)         (((ns) + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_CNT_W           15
`define SWL_CMD_OD_SKIP     8'h3c
`define SWL_CRC_POLY        16'ha001
`define SWL_CRC_INIT        16'h0000
`endif

// file: swl_crc16.v
`timescale 1ns/1ps
`include "swl_consts.vh"
// Running CRC-16 over bits sent or received, least significant bit first.
module swl_crc16 (
    // Clock and reset
    input  wire        clock_i,
    input  wire        resetn_i,
    // Control
    input  wire        clear_i,
    input  wire        bit_valid_i,
    input  wire        bit_i,
    // Result
    output reg  [15:0] crc_o
);
    wire fb = crc_o[0] ^ bit_i;

    always @(posedge clock_i) begin
        if (!resetn_i || clear_i) begin
            crc_o <= `SWL_CRC_INIT;
        end else if (bit_valid_i) begin
            crc_o <= fb ? ((crc_o >> 1) ^ `SWL_CRC_POLY) : (crc_o >> 1);
        end
    end
endmodule // swl_crc16

// file: swl_host.v
`timescale 1ns/1ps
`include "swl_consts.vh"
module swl_host (
    // Clock and reset
    input  wire       clock_i,
    input  wire       resetn_i,
    // Requests
    input  wire       reset_req_i,
    input  wire       bit_req_i,
    input  wire       bit_i,
    input  wire       overdrive_i,
    input  wire       crc_clear_i,
    // Answers
    output wire       ready_o,
    output reg        done_o,
    output reg        presence_o,
    output reg        bit_o,
    output reg        overdrive_o,
    output wire [15:0] crc_o,
    // Bus line
    input  wire       line_i,
    output wire       line_o,
    output reg        line_oe_o
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RLOW = 5'h02;
    localparam [4:0] S_RHI  = 5'h04;
    localparam [4:0] S_SLOW = 5'h08;
    localparam [4:0] S_SREC = 5'h10;

    // Cycle counts are worked out at full width, then cut to the counter width.
    localparam integer N_RSTL_S = `SWL_CYC(`SWL_RSTL_STD_NS + `SWL_FALL_NS);
    localparam integer N_RSTL_O = `SWL_CYC(`SWL_RSTL_OD_NS + `SWL_FALL_NS);
    localparam integer N_RSTH_S = `SWL_CYC(`SWL_RSTH_STD_NS);
    localparam integer N_RSTH_O = `SWL_CYC(`SWL_RSTH_OD_NS);
    localparam integer N_MSP_S  = `SWL_CYC(`SWL_MSP_STD_NS);
    localparam integer N_MSP_O  = `SWL_CYC(`SWL_MSP_OD_NS);
    localparam integer N_SLOT_S = `SWL_CYC(`SWL_SLOT_STD_NS);
    localparam integer N_SLOT_O = `SWL_CYC(`SWL_SLOT_OD_NS);
    localparam integer N_W0L_S  = `SWL_CYC(`SWL_W0L_STD_NS);
    localparam integer N_W0L_O  = `SWL_CYC(`SWL_W0L_OD_NS);
    localparam integer N_W1L_S  = `SWL_CYC(`SWL_W1L_STD_NS);
    localparam integer N_W1L_O  = `SWL_CYC(`SWL_W1L_OD_NS);
    localparam integer N_MSR_S  = `SWL_CYC(`SWL_MSR_STD_NS);
    localparam integer N_MSR_O  = `SWL_CYC(`SWL_MSR_OD_NS);

    localparam [14:0] C_RSTL_S = N_RSTL_S[14:0];
    localparam [14:0] C_RSTL_O = N_RSTL_O[14:0];
    localparam [14:0] C_RSTH_S = N_RSTH_S[14:0];
    localparam [14:0] C_RSTH_O = N_RSTH_O[14:0];
    localparam [14:0] C_MSP_S  = N_MSP_S[14:0];
    localparam [14:0] C_MSP_O  = N_MSP_O[14:0];
    localparam [14:0] C_SLOT_S = N_SLOT_S[14:0];
    localparam [14:0] C_SLOT_O = N_SLOT_O[14:0];
    localparam [14:0] C_W0L_S  = N_W0L_S[14:0];
    localparam [14:0] C_W0L_O  = N_W0L_O[14:0];
    localparam [14:0] C_W1L_S  = N_W1L_S[14:0];
    localparam [14:0] C_W1L_O  = N_W1L_O[14:0];
    localparam [14:0] C_MSR_S  = N_MSR_S[14:0];
    localparam [14:0] C_MSR_O  = N_MSR_O[14:0];

    reg  [4:0]  state;
    reg  [14:0] count;
    reg         od;
    reg         tx_bit;
    reg  [7:0]  shift;
    reg  [2:0]  nbit;
    reg         line_m;
    reg         line_s;
    reg         crc_step;
    reg         crc_val;
    reg         sel_byte;

    // Picks the standard or overdrive count.
    function [14:0] pick;
        input        sel_od;
        input [14:0] c_std;
        input [14:0] c_od;
        begin
            pick = sel_od ? c_od : c_std;
        end
    endfunction

    assign ready_o = (state == S_IDLE);
    assign line_o  = 1'b0;

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            line_m <= 1'b1;
            line_s <= 1'b1;
        end else begin
            line_m <= line_i;
            line_s <= line_m;
        end
    end

    always @(posedge clock_i) begin
        if (!resetn_i) begin
            state       <= S_IDLE;
            count       <= 15'h0000;
            od          <= 1'b0;
            tx_bit      <= 1'b1;
            shift       <= 8'h00;
            nbit        <= 3'h0;
            done_o      <= 1'b0;
            presence_o  <= 1'b0;
            bit_o       <= 1'b0;
            overdrive_o <= 1'b0;
            line_oe_o   <= 1'b0;
            crc_step    <= 1'b0;
            crc_val     <= 1'b0;
            sel_byte    <= 1'b0;
        end else begin
            done_o   <= 1'b0;
            crc_step <= 1'b0;
            count    <= count + 15'h0001;
            // A write-zero slot is still low at the sample point, so both slot states sample.
            if ((state == S_SLOW || state == S_SREC) && count == pick(od, C_MSR_S, C_MSR_O)) begin
                bit_o    <= line_s;
                crc_val  <= line_s;
                crc_step <= 1'b1;
                shift    <= {line_s, shift[7:1]};
                nbit     <= nbit + 3'h1;
            end
            case (state)
                S_IDLE: begin
                    line_oe_o <= 1'b0;
                    count     <= 15'h0000;
                    if (reset_req_i) begin
                        // A standard reset is long enough to clear overdrive everywhere.
                        od        <= overdrive_i;
                        line_oe_o <= 1'b1;
                        state     <= S_RLOW;
                    end else if (bit_req_i) begin
                        tx_bit    <= bit_i;
                        line_oe_o <= 1'b1;
                        state     <= S_SLOW;
                    end
                end
                S_RLOW: begin
                    if (count + 15'h0001 >= pick(od, C_RSTL_S, C_RSTL_O)) begin
                        line_oe_o  <= 1'b0;
                        count      <= 15'h0000;
                        presence_o <= 1'b0;
                        nbit       <= 3'h0;
                        sel_byte   <= 1'b1;
                        state      <= S_RHI;
                    end
                end
                S_RHI: begin
                    if (count == pick(od, C_MSP_S, C_MSP_O)) begin
                        presence_o <= ~line_s;
                    end
                    if (count + 15'h0001 >= pick(od, C_RSTH_S, C_RSTH_O)) begin
                        overdrive_o <= od;
                        done_o      <= 1'b1;
                        state       <= S_IDLE;
                    end
                end
                S_SLOW: begin
                    // One bit low time bounds every data slot well below the reset limit.
                    if (count + 15'h0001 >= (tx_bit ? pick(od, C_W1L_S, C_W1L_O)
                                                   : pick(od, C_W0L_S, C_W0L_O))) begin
                        line_oe_o <= 1'b0;
                        state     <= S_SREC;
                    end
                end
                S_SREC: begin
                    if (count + 15'h0001 >= pick(od, C_SLOT_S, C_SLOT_O)) begin
                        // Only the first byte after a reset may switch this end to overdrive.
                        if (nbit == 3'h0 && sel_byte) begin
                            sel_byte <= 1'b0;
                            if (shift == `SWL_CMD_OD_SKIP && !od) begin
                                od          <= 1'b1;
                                overdrive_o <= 1'b1;
                            end
                        end
                        done_o <= 1'b1;
                        state  <= S_IDLE;
                    end
                end
                default: begin
                    line_oe_o <= 1'b0;
                    state     <= S_IDLE;
                end
            endcase
        end
    end

    swl_crc16 u_crc (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .clear_i     (crc_clear_i),
        .bit_valid_i (crc_step),
        .bit_i       (crc_val),
        .crc_o       (crc_o)
    );
endmodule // swl_host

// file: swl_host_asserts.sv
`timescale 1ns/1ps
module swl_host_asserts (
    input wire clock_i,
    input wire resetn_i,
    input wire reset_req_i,
    input wire bit_req_i,
    input wire overdrive_i,
    input wire ready_o,
    input wire done_o,
    input wire overdrive_o,
    input wire line_o,
    input wire line_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    reg [1:0]  kind;
    reg [15:0] lo_n;
    reg [15:0] hi_n;
    always @(posedge clock_i) begin
        if (ready_o && (reset_req_i || bit_req_i))
            kind <= reset_req_i ? {1'b0, overdrive_i} : 2'h2;
        lo_n <= line_oe_o ? lo_n + 16'h1 : 16'h0;
        hi_n <= line_oe_o ? 16'h0 : hi_n + 16'h1;
    end
    a_line_low: assert property (line_o == 1'b0) else $error("line driven high");
    a_reset_idle: assert property (disable iff (1'b0)
        !resetn_i |=> !line_oe_o && !done_o && !overdrive_o) else $error("bad reset state");
    a_reset_start: assert property (
        ready_o && reset_req_i |=> line_oe_o && !ready_o) else $error("reset not started");
    a_slot_start: assert property (
        ready_o && bit_req_i && !reset_req_i |=> line_oe_o && !ready_o) else $error("no slot");
    a_std_low: assert property ($fell(line_oe_o) && kind == 2'h0
        |-> lo_n >= 16'h4b00 && lo_n <= 16'h4b0a) else $error("standard reset length");
    a_od_low: assert property ($fell(line_oe_o) && kind == 2'h1
        |-> lo_n >= 16'h0af0 && lo_n <= 16'h0c80) else $error("overdrive reset length");
    a_slot_low: assert property ($fell(line_oe_o) && kind == 2'h2
        |-> lo_n <= (overdrive_o ? 16'h026c : 16'h12c0)) else $error("slot low too long");
    a_high_wait: assert property ($rose(ready_o) && !kind[1]
        |-> hi_n >= (kind[0] ? 16'h0780 : 16'h4b00)) else $error("reset high too short");
    a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    a_speed_step: assert property ($changed(overdrive_o) |-> done_o) else $error("speed moved");
endmodule // swl_host_asserts
bind swl_host swl_host_asserts chk_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .reset_req_i(reset_req_i), .bit_req_i(bit_req_i), .overdrive_i(overdrive_i),
    .ready_o(ready_o), .done_o(done_o), .overdrive_o(overdrive_o), .line_o(line_o),
    .line_oe_o(line_oe_o));

// file: swl_dev_model.sv
`timescale 1ns/1ps
module swl_dev_model (
    input  wire clock_i,
    input  wire line_i,
    input  wire present_i,
    input  wire zero_i,
    output reg  pull_o = 1'b0
);
    reg        od = 1'b0;
    reg        prv = 1'b1;
    reg        own = 1'b0;
    reg [15:0] lo = 16'h0;
    reg [15:0] pr = 16'hffff;
    reg [15:0] rd = 16'hffff;
    reg [3:0]  nb = 4'h0;
    reg [7:0]  rx = 8'h0;
    wire       b = lo < (od ? 16'h0064 : 16'h03e8);
    always @(posedge clock_i) begin
        prv <= line_i;
        lo <= line_i ? 16'h0 : lo + 16'h1;
        pr <= pr + {15'h0, pr != 16'hffff};
        rd <= (prv && !line_i && !pull_o && zero_i) ? 16'h0 : rd + {15'h0, rd != 16'hffff};
        pull_o <= (present_i && pr >= (od ? 16'h0050 : 16'h0258) && pr < (od ? 16'h0190 : 16'h12c0))
            || rd < (od ? 16'h0078 : 16'h04b0);
        if (!prv && line_i) begin
            own <= 1'b0;
            if (!own && lo >= 16'h4b00) od <= 1'b0;
            if (!own && lo > (od ? 16'h026c : 16'h12c0)) begin
                pr <= 16'h0;
                nb <= 4'h0;
            end else if (!own && nb < 4'h8) begin
                rx <= {b, rx[7:1]};
                nb <= nb + 4'h1;
                if (nb == 4'h7 && {b, rx[7:1]} == 8'h3c) od <= 1'b1;
            end
        end else if (pull_o) own <= 1'b1;
    end
endmodule // swl_dev_model

// file: swl_host_bench.sv
`timescale 1ns/1ps
module swl_host_bench;
    reg         clock_i = 1'b0, resetn_i = 1'b0, reset_req_i = 1'b0, bit_req_i = 1'b0;
    reg         bit_i = 1'b0, overdrive_i = 1'b0, crc_clear_i = 1'b0, present = 1'b1, zero = 1'b0;
    reg  [15:0] crc = 16'h0;
    reg  [5:0]  rows [0:12];
    wire        ready_o, done_o, presence_o, bit_o, overdrive_o, line_o, line_oe_o, pull;
    wire [15:0] crc_o;
    wire        line = (line_oe_o ? line_o : 1'b1) & ~pull;
    integer     n_mismatch = 0, tests_run = 0, cyc = 0, i;
    always #12.5 clock_i = ~clock_i;
    swl_host dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reset_req_i(reset_req_i),
        .bit_req_i(bit_req_i), .bit_i(bit_i), .overdrive_i(overdrive_i), .crc_clear_i(crc_clear_i),
        .ready_o(ready_o), .done_o(done_o), .presence_o(presence_o), .bit_o(bit_o),
        .overdrive_o(overdrive_o), .crc_o(crc_o), .line_i(line), .line_o(line_o),
        .line_oe_o(line_oe_o));
    swl_dev_model dev_u (.clock_i(clock_i), .line_i(line), .present_i(present), .zero_i(zero),
        .pull_o(pull));
    task check(input [31:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task op(input r, input b, input od, input z);
        begin
            @(posedge clock_i);
            reset_req_i <= r;
            bit_req_i <= !r;
            bit_i <= b;
            overdrive_i <= od;
            zero <= z;
            @(posedge clock_i);
            reset_req_i <= 1'b0;
            bit_req_i <= 1'b0;
            do @(negedge clock_i); while (done_o !== 1'b1);
        end
    endtask
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    initial begin
        rows = '{6'h22, 6'h00, 6'h00, 6'h12, 6'h12, 6'h12, 6'h12, 6'h00, 6'h01, 6'h2b, 6'h15,
                 6'h13, 6'h01};
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        check("oe", line_oe_o, 1'b0);
        for (i = 0; i < 13; i = i + 1) begin
            op(rows[i][5], rows[i][4], rows[i][3], rows[i][2]);
            if (rows[i][5]) check("pres", presence_o, rows[i][1]);
            else begin
                check("bit", bit_o, rows[i][1]);
                crc = {1'b0, crc[15:1]} ^ ((crc[0] ^ rows[i][1]) ? 16'ha001 : 16'h0000);
                check("crc", crc_o, crc);
            end
            check("spd", overdrive_o, rows[i][0]);
        end
        // An overdrive reset with nobody answering keeps the speed and sees no presence.
        @(posedge clock_i);
        present <= 1'b0;
        op(1'b1, 1'b0, 1'b1, 1'b0);
        check("pres", presence_o, 1'b0);
        check("spd", overdrive_o, 1'b1);
        // A reset of this block in overdrive must bring it back to standard speed.
        @(posedge clock_i);
        crc_clear_i <= 1'b1;
        @(posedge clock_i);
        crc_clear_i <= 1'b0;
        resetn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        check("crc", crc_o, 16'h0);
        check("spd", overdrive_o, 1'b0);
        check("rdy", ready_o, 1'b1);
        close_out;
    end
endmodule // swl_host_bench
